// ### hw/mvr_core.sv
// execution of the move and return instruction group of the 8-bit core

module mvr_core (
   input wire logic REF_CLK_I,
   input wire logic RESETN_I,
   input wire logic [13:0] INSTR_I,
   input wire logic INSTR_VALID_I,
   input wire logic [12:0] STACK_TOP_I,
   output logic [12:0] PC_O,
   output logic [7:0] ACC_O,
   output logic GLOBAL_IRQ_ENABLE_O,
   output logic FILE_WE_O,
   output logic [6:0] FILE_ADDR_O,
   output logic [7:0] FILE_DATA_O,
   output logic STACK_POP_O,
   output logic FLUSH_O
);

   // ******************************************************************
   // decoded view of the instruction word
   // ******************************************************************
   // the instruction word comes from program memory on this same clock,
   // so it feeds the decoder directly with no synchroniser in between
   mvr_pkg::mvr_dec_t dec;

   mvr_decode u_decode (
      .instr_i(INSTR_I),
      .dec_o(dec)
   );

   // ******************************************************************
   // registered state
   // ******************************************************************
   // sequencing state: executing, or burning the second return cycle
   mvr_pkg::mvr_state_t state;
   mvr_pkg::mvr_state_t next_state;

   // program counter and working accumulator
   logic [12:0] pc;
   logic [12:0] next_pc;
   logic [7:0] acc;
   logic [7:0] next_acc;

   // global_irq_enable, bit 7 of interrupt_control_reg
   logic irq_en;
   logic next_irq_en;

   // file register write port, registered so the outputs come from flops
   logic file_we;
   logic next_file_we;
   logic [6:0] file_addr;
   logic [6:0] next_file_addr;
   logic [7:0] file_data;
   logic [7:0] next_file_data;

   // return stack pop strobe and flush marker
   logic stack_pop;
   logic next_stack_pop;
   logic flush;
   logic next_flush;

   // ******************************************************************
   // next state and datapath
   // ******************************************************************
   // one process works out every next value; strobes default low so a
   // write or a pop can never be repeated by a later cycle
   always_comb begin
      next_state = state;
      next_pc = pc;
      next_acc = acc;
      next_irq_en = irq_en;
      next_file_we = 1'b0;
      next_file_addr = file_addr;
      next_file_data = file_data;
      next_stack_pop = 1'b0;
      next_flush = 1'b0;
      unique case (state)
         mvr_pkg::ST_EXEC: begin
            // a word is only executed while valid; otherwise all holds but the strobes, which drop low
            if (INSTR_VALID_I) begin
               // every one-word, one-cycle instruction steps the pc
               next_pc = pc + 13'h0001;
               unique case (dec.op)
                  mvr_pkg::OP_STORE: begin
                     // accumulator to the addressed file register
                     next_file_we = 1'b1;
                     next_file_addr = dec.addr;
                     next_file_data = acc;
                  end
                  mvr_pkg::OP_LOAD_LIT: begin
                     // literal straight into the accumulator
                     next_acc = dec.lit;
                  end
                  mvr_pkg::OP_IDLE: begin
                     // nothing but the pc step above
                     next_acc = acc;
                  end
                  mvr_pkg::OP_RET_LIT: begin
                     // literal in, stored return address out
                     next_acc = dec.lit;
                     next_pc = STACK_TOP_I;
                     next_stack_pop = 1'b1;
                     next_flush = 1'b1;
                     next_state = mvr_pkg::ST_FLUSH;
                  end
                  mvr_pkg::OP_IRQ_RET: begin
                     // return and enable interrupts in one operation
                     next_pc = STACK_TOP_I;
                     next_stack_pop = 1'b1;
                     next_irq_en = 1'b1;
                     next_flush = 1'b1;
                     next_state = mvr_pkg::ST_FLUSH;
                  end
                  mvr_pkg::OP_RET: begin
                     // plain return leaves the accumulator alone
                     next_pc = STACK_TOP_I;
                     next_stack_pop = 1'b1;
                     next_flush = 1'b1;
                     next_state = mvr_pkg::ST_FLUSH;
                  end
                  mvr_pkg::OP_OTHER: begin
                     // other groups execute elsewhere; only the pc steps
                     next_acc = acc;
                  end
                  default: begin
                     // unused op code: treat as a step, change nothing
                     next_acc = acc;
                  end
               endcase
            end
         end
         mvr_pkg::ST_FLUSH: begin
            // second cycle of a return; the prefetched word is dropped
            // here, which is why returns cost two cycles
            next_state = mvr_pkg::ST_EXEC;
         end
      endcase
   end

   // ******************************************************************
   // registers
   // ******************************************************************
   // asynchronous active-low reset, constants only in the reset branch
   always_ff @(posedge REF_CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         state <= mvr_pkg::ST_EXEC;
         pc <= mvr_pkg::PC_RST;
         acc <= mvr_pkg::ACC_RST;
         irq_en <= mvr_pkg::IRQ_EN_RST;
         file_we <= 1'b0;
         file_addr <= 7'h00;
         file_data <= 8'h00;
         stack_pop <= 1'b0;
         flush <= 1'b0;
      end else begin
         state <= next_state;
         pc <= next_pc;
         acc <= next_acc;
         irq_en <= next_irq_en;
         file_we <= next_file_we;
         file_addr <= next_file_addr;
         file_data <= next_file_data;
         stack_pop <= next_stack_pop;
         flush <= next_flush;
      end
   end

   // ******************************************************************
   // outputs
   // ******************************************************************
   // every output is a flop; the flush marker equals the flush state
   assign PC_O = pc;
   assign ACC_O = acc;
   assign GLOBAL_IRQ_ENABLE_O = irq_en;
   assign FILE_WE_O = file_we;
   assign FILE_ADDR_O = file_addr;
   assign FILE_DATA_O = file_data;
   assign STACK_POP_O = stack_pop;
   assign FLUSH_O = flush;

endmodule // mvr_core

// ### hw/mvr_decode.sv
// opcode decoder of the move and return instruction group
module mvr_decode (
   input wire logic [13:0] instr_i,
   output mvr_pkg::mvr_dec_t dec_o
);

   // ******************************************************************
   // decode
   // ******************************************************************
   // masked compares, exact ones for IRQ_RET_CODE and RET_CODE; literal forms ignore their two spare opcode bits
   always_comb begin
      dec_o.addr = instr_i[6:0];
      dec_o.lit = instr_i[7:0];
      if ((instr_i & mvr_pkg::STORE_MASK) == mvr_pkg::STORE_CODE) begin
         dec_o.op = mvr_pkg::OP_STORE;
      end else if ((instr_i & mvr_pkg::LOAD_LIT_MASK) == mvr_pkg::LOAD_LIT_CODE) begin
         dec_o.op = mvr_pkg::OP_LOAD_LIT;
      end else if ((instr_i & mvr_pkg::RET_LIT_MASK) == mvr_pkg::RET_LIT_CODE) begin
         dec_o.op = mvr_pkg::OP_RET_LIT;
      end else if (instr_i == mvr_pkg::IRQ_RET_CODE) begin
         dec_o.op = mvr_pkg::OP_IRQ_RET;
      end else if (instr_i == mvr_pkg::RET_CODE) begin
         dec_o.op = mvr_pkg::OP_RET;
      end else if ((instr_i & mvr_pkg::IDLE_MASK) == mvr_pkg::IDLE_CODE) begin
         dec_o.op = mvr_pkg::OP_IDLE;
      end else begin
         dec_o.op = mvr_pkg::OP_OTHER;
      end
   end

endmodule // mvr_decode

// ### hw/mvr_pkg.sv
// shared constants and types of the move and return execution block
package mvr_pkg;

   // ******************************************************************
   // widths
   // ******************************************************************
   localparam int INSTR_W = 14;
   localparam int PC_W = 13;
   localparam int DATA_W = 8;
   localparam int FADDR_W = 7;

   // ******************************************************************
   // opcode patterns, compared under their masks; IRQ_RET_CODE and RET_CODE exactly
   // ******************************************************************
   localparam logic [13:0] STORE_MASK = 14'h3f80;
   localparam logic [13:0] STORE_CODE = 14'h0080;
   localparam logic [13:0] LOAD_LIT_MASK = 14'h3c00;
   localparam logic [13:0] LOAD_LIT_CODE = 14'h3000;
   localparam logic [13:0] RET_LIT_MASK = 14'h3c00;
   localparam logic [13:0] RET_LIT_CODE = 14'h3400;
   localparam logic [13:0] IDLE_MASK = 14'h3f9f;
   localparam logic [13:0] IDLE_CODE = 14'h0000;
   localparam logic [13:0] IRQ_RET_CODE = 14'h0009;
   localparam logic [13:0] RET_CODE = 14'h0008;

   // ******************************************************************
   // reset values and field positions
   // ******************************************************************
   localparam logic [12:0] PC_RST = 13'h0000;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic IRQ_EN_RST = 1'b0;
   localparam int IRQ_EN_BIT = 7;

   // ******************************************************************
   // types
   // ******************************************************************
   typedef enum logic [2:0] {
      OP_OTHER = 3'b000,
      OP_STORE = 3'b001,
      OP_LOAD_LIT = 3'b010,
      OP_IDLE = 3'b011,
      OP_IRQ_RET = 3'b100,
      OP_RET_LIT = 3'b101,
      OP_RET = 3'b110
   } mvr_op_t;

   typedef struct packed {
      mvr_op_t op;
      logic [6:0] addr;
      logic [7:0] lit;
   } mvr_dec_t;

   typedef enum logic {
      ST_EXEC = 1'b0,
      ST_FLUSH = 1'b1
   } mvr_state_t;

endpackage : mvr_pkg

// ### tb/mvr_chk.sv
// port assertions of the move and return core
module mvr_chk (input wire logic REF_CLK_I, RESETN_I, INSTR_VALID_I, FLUSH_O, FILE_WE_O,
   GLOBAL_IRQ_ENABLE_O, input wire logic [13:0] INSTR_I, input wire logic [12:0] PC_O,
   STACK_TOP_I, input wire logic [7:0] ACC_O, FILE_DATA_O);
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (!RESETN_I);
   // a flush cycle carries no instruction
   wire t = INSTR_VALID_I && !FLUSH_O;
   wire rt = t && INSTR_I == 14'h0008;
   wire ri = t && INSTR_I == 14'h0009;
   wire rr = rt || ri || t && INSTR_I[13:10] == 4'hd;
   wire lt = t && INSTR_I[13:11] == 3'h6;
   wire [7:0] k = INSTR_I[7:0];
   chk_st_we: assert property (t && INSTR_I[13:7] == 7'h01 |=> FILE_WE_O) else $error("st");
   chk_st_data: assert property (FILE_WE_O |-> FILE_DATA_O == ACC_O) else $error("sd");
   chk_lit_acc: assert property (lt |=> ACC_O == $past(k)) else $error("la");
   chk_ret_flush: assert property (rr |=> FLUSH_O ##1 !FLUSH_O) else $error("rf");
   chk_ret_pc: assert property (rr |=> ##1 PC_O == $past(STACK_TOP_I, 2)) else $error("rp");
   chk_irq_en: assert property (ri |-> ##[1:2] GLOBAL_IRQ_ENABLE_O) else $error("ie");
   chk_ret_acc: assert property (rt |=> ##1 ACC_O == $past(ACC_O, 2)) else $error("ra");
   chk_idle_pc: assert property (t && INSTR_I == 14'h0000 |=> PC_O == $past(PC_O) + 13'h0001)
      else $error("id");
endmodule // mvr_chk
bind mvr_core mvr_chk u_chk (.*);

// ### tb/mvr_mem.sv
// behavioural file registers and return stack beside the core
module mvr_mem (input wire logic clk_i, we_i, pop_i, input wire logic [6:0] adr_i,
   input wire logic [7:0] dat_i, output logic [12:0] top_o = 13'h0456);
   logic [7:0] regs [128];
   // each pop shows a new return address, so a stale one is caught
   always @(posedge clk_i) begin
      if (we_i) regs[adr_i] <= dat_i;
      if (pop_i) top_o <= top_o + 13'h0123;
   end
endmodule // mvr_mem

// ### tb/test_move_and_return_execution.sv
// random and corner instruction mix for the move and return core
module test_move_and_return_execution;
   timeunit 1ns;
   timeprecision 1ps;
   logic REF_CLK_I = 1'h0, RESETN_I = 1'h0, INSTR_VALID_I = 1'h0, g, we, pop, fl;
   logic [13:0] INSTR_I = 14'h0000;
   logic [12:0] pc, top, e;
   logic [7:0] acc, d, k;
   logic [6:0] wa;
   logic [15:0] r = 16'h0007;
   int n_fail = 0, n_compared = 0, i, j;
   always #4 REF_CLK_I = ~REF_CLK_I;
   mvr_core dut (.REF_CLK_I, .RESETN_I, .INSTR_I, .INSTR_VALID_I, .STACK_TOP_I(top), .PC_O(pc),
      .ACC_O(acc), .GLOBAL_IRQ_ENABLE_O(g), .FILE_WE_O(we), .FILE_ADDR_O(wa), .FILE_DATA_O(d),
      .STACK_POP_O(pop), .FLUSH_O(fl));
   mvr_mem u_mem (.clk_i(REF_CLK_I), .we_i(we), .pop_i(pop), .adr_i(wa), .dat_i(d), .top_o(top));
   task automatic cmp(input logic [12:0] got, exp);
      n_compared++;
      if (got !== exp) begin n_fail++; $display("[ERR] %0t %h %h", $time, got, exp); end
   endtask
   task automatic conclude();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // one instruction; the valid is dropped during flush so nothing is taken twice
   task automatic go(input logic [13:0] x);
      INSTR_I = x;
      INSTR_VALID_I = 1'h1;
      @(posedge REF_CLK_I) #1;
      for (j = 0; j < 3 && fl !== 1'h0; j++) begin INSTR_VALID_I = 1'h0; @(posedge REF_CLK_I) #1; end
      if (fl !== 1'h0) begin n_fail++; conclude(); end
   endtask
   initial begin
      repeat (4) @(posedge REF_CLK_I);
      #1 RESETN_I = 1'h1;
      cmp(g, 1'h0); cmp(pc, 13'h0000); cmp(acc, 8'h00);
      for (i = 0; i < 400; i++) begin
         r = {r[14:0], r[15] ^ r[13] ^ r[12] ^ r[10]};
         k = (i < 16) ? {8{i[0]}} : r[15:8];
         e = top;
         case (r[2:0])
            3'h0: begin go({4'hc, r[9:8], k}); cmp(acc, k); end
            3'h1: begin go({6'h30, k}); cmp(acc, k); end
            3'h2: begin go({4'hd, r[9:8], k}); cmp(acc, k); cmp(pc, e); end
            3'h3: begin k = acc; go({7'h01, r[14:8]}); cmp(acc, k); cmp(we, 1'h1); end
            3'h4: begin k = acc; e = pc + 13'h0001; go(14'h0000); cmp(pc, e); cmp(acc, k); end
            3'h5: begin k = acc; go(14'h0008); cmp(pc, e); cmp(acc, k); end
            3'h6: begin go(14'h0008); cmp(top, e + 13'h0123); end
            default: begin go(14'h0009); cmp(g, 1'h1); cmp(pc, e); end
         endcase
         if (r[2:0] == 3'h3) begin cmp(wa, r[14:8]); cmp(d, k); end
      end
      $display("instruction mix done");
      conclude();
   end
endmodule // test_move_and_return_execution
